/* hdl/ddcnm_pair_buf.sv */
`timescale 1ns/1ps
module ddcnm_pair_buf #(parameter int unsigned W = 20) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic flush,
    ddcnm_stream_if.sink up,
    ddcnm_stream_if.source dn
);
    import ddcnm_pkg::*;

    // head entry feeds the outputs straight from a register
    logic [2*W-1:0] head_q, head_d, tail_q, tail_d;
    logic [1:0] count_q, count_d;
    logic in_rdy_q, in_rdy_d, out_vld_q, out_vld_d;
    logic push, pop;

    assign push = up.valid & in_rdy_q;
    assign pop = out_vld_q & dn.ready;

    // shift-style two entry queue
    always_comb begin
        head_d = head_q;
        tail_d = tail_q;
        count_d = count_q;
        if (flush) begin
            count_d = 2'd0;
        end else begin
            if (pop) begin
                head_d = tail_q;
            end
            if (push) begin
                if (count_q == 2'd0 || (pop && count_q == 2'd1)) begin
                    head_d = {up.i_data, up.q_data};
                end else begin
                    tail_d = {up.i_data, up.q_data};
                end
            end
            count_d = count_q + 2'(push) - 2'(pop);
        end
        in_rdy_d = (count_d != 2'd2);
        out_vld_d = (count_d != 2'd0);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            head_q <= '0;
            tail_q <= '0;
            count_q <= 2'd0;
            in_rdy_q <= 1'b0;
            out_vld_q <= 1'b0;
        end else if (ce) begin
            head_q <= head_d;
            tail_q <= tail_d;
            count_q <= count_d;
            in_rdy_q <= in_rdy_d;
            out_vld_q <= out_vld_d;
        end
    end

    assign up.ready = in_rdy_q;
    assign dn.valid = out_vld_q;
    assign dn.i_data = head_q[2*W-1:W];
    assign dn.q_data = head_q[W-1:0];
endmodule // ddcnm_pair_buf

/* hdl/ddcnm_top.sv */
`timescale 1ns/1ps
// Notes on behaviour
// - eight presets, each accumulator running unless powered down
// - three-bit preset index register field
// - config bit0 picks pins or register
// - 32-bit word added per clock
// - 16-bit offset added in upper half
// - sample times complex exponential gives I/Q
// - rational mode wraps at 128 times divisor
// - power-down disables all serial outputs
// - full-scale trim from two registers
// - offset trim ignored under background calibration
module ddcnm_top #(parameter int unsigned SAMPLE_W = 12) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ddcnm_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    input wire logic [ddcnm_pkg::IDX_W-1:0] preset_select_pins,
    input wire logic [SAMPLE_W-1:0] adc_sample,
    input wire logic adc_valid,
    output logic adc_ready,
    output logic out_valid,
    input wire logic out_ready,
    output logic [SAMPLE_W+ddcnm_pkg::TRIG_W-1:0] out_i,
    output logic [SAMPLE_W+ddcnm_pkg::TRIG_W-1:0] out_q,
    output logic serial_drive_en,
    output logic [ddcnm_pkg::IDX_W-1:0] active_preset,
    output logic [2*ddcnm_pkg::TRIM_W-1:0] full_scale_trim,
    output logic [2*ddcnm_pkg::TRIM_W-1:0] input_offset_trim
);
    import ddcnm_pkg::*;

    localparam int unsigned OUT_W = SAMPLE_W + TRIG_W;

    // products are sized for sample widths up to 16 bits
    if (SAMPLE_W < 2 || SAMPLE_W > 16) begin : g_bad_width
        $error("ddcnm_top: SAMPLE_W must be 2..16");
    end

    // full-turn sine table, 16 points, amplitude 127
    function automatic logic signed [TRIG_W-1:0] sine_of(input logic [LUT_W-1:0] a);
        unique case (a)
            4'h0: sine_of = 8'sh00;
            4'h1: sine_of = 8'sh31;
            4'h2: sine_of = 8'sh5A;
            4'h3: sine_of = 8'sh75;
            4'h4: sine_of = 8'sh7F;
            4'h5: sine_of = 8'sh75;
            4'h6: sine_of = 8'sh5A;
            4'h7: sine_of = 8'sh31;
            4'h8: sine_of = 8'sh00;
            4'h9: sine_of = 8'shCF;
            4'hA: sine_of = 8'shA6;
            4'hB: sine_of = 8'sh8B;
            4'hC: sine_of = 8'sh81;
            4'hD: sine_of = 8'sh8B;
            4'hE: sine_of = 8'shA6;
            4'hF: sine_of = 8'shCF;
        endcase
    endfunction

    // aligned and inside the map
    function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
        logic [REG_IDX_W-1:0] i;
        i = a[ADDR_W-1:BYTE_SHIFT];
        addr_ok = (a[BYTE_SHIFT-1:0] == '0) &&
            (i == IDX_GAIN_A || i == IDX_GAIN_B || i == IDX_OFFS_A || i == IDX_OFFS_B ||
             i == IDX_SRC_CFG || i == IDX_SEL || i == IDX_RDIV || i == IDX_CTRL ||
             i == IDX_STATUS || (i >= IDX_FREQ_BASE && i < IDX_PHASE_END));
    endfunction

    // register file over apb
    logic [TRIM_W-1:0] gain_a_q, gain_a_d, gain_b_q, gain_b_d;
    logic [TRIM_W-1:0] offs_a_q, offs_a_d, offs_b_q, offs_b_d;
    logic src_q, src_d;
    logic [IDX_W-1:0] sel_q, sel_d;
    logic [31:0] freq_q [N_PRESETS];
    logic [31:0] freq_d [N_PRESETS];
    logic [PHASE_W-1:0] phoff_q [N_PRESETS];
    logic [PHASE_W-1:0] phoff_d [N_PRESETS];
    logic [RDIV_W-1:0] rdiv_q, rdiv_d;
    logic [CTRL_W-1:0] ctrl_q, ctrl_d;
    logic pready_q, pready_d, pslverr_q, pslverr_d;
    logic [31:0] prdata_q, prdata_d;
    logic [REG_IDX_W-1:0] idx;
    logic setup, done, wr_ok, rdiv_wr;
    logic div_busy, pd, rat_on;
    logic [IDX_W-1:0] act_idx;

    assign idx = paddr[ADDR_W-1:BYTE_SHIFT];
    // no wait state: pready rises in the first access cycle
    assign setup = psel & ~penable & ~pready_q;
    assign done = psel & penable & pready_q;
    assign wr_ok = done & pwrite & addr_ok(paddr);
    assign rdiv_wr = wr_ok & (idx == IDX_RDIV);

    always_comb begin
        gain_a_d = gain_a_q;
        gain_b_d = gain_b_q;
        offs_a_d = offs_a_q;
        offs_b_d = offs_b_q;
        src_d = src_q;
        sel_d = sel_q;
        freq_d = freq_q;
        phoff_d = phoff_q;
        rdiv_d = rdiv_q;
        ctrl_d = ctrl_q;
        pready_d = setup;
        pslverr_d = setup & ~addr_ok(paddr);
        prdata_d = prdata_q;
        if (setup) begin
            prdata_d = '0;
            if (!pwrite && addr_ok(paddr)) begin
                if (idx >= IDX_FREQ_BASE && idx < IDX_FREQ_END) begin
                    prdata_d = freq_q[idx[IDX_W-1:0]];
                end else if (idx >= IDX_PHASE_BASE && idx < IDX_PHASE_END) begin
                    prdata_d[PHASE_W-1:0] = phoff_q[idx[IDX_W-1:0]];
                end else begin
                    case (idx)
                        IDX_GAIN_A: prdata_d[TRIM_W-1:0] = gain_a_q;
                        IDX_GAIN_B: prdata_d[TRIM_W-1:0] = gain_b_q;
                        IDX_OFFS_A: prdata_d[TRIM_W-1:0] = offs_a_q;
                        IDX_OFFS_B: prdata_d[TRIM_W-1:0] = offs_b_q;
                        IDX_SRC_CFG: prdata_d[SRC_BIT] = src_q;
                        IDX_SEL: prdata_d[IDX_W-1:0] = sel_q;
                        IDX_RDIV: prdata_d[RDIV_W-1:0] = rdiv_q;
                        IDX_CTRL: prdata_d[CTRL_W-1:0] = ctrl_q;
                        // live status: pd, rational, busy, index
                        IDX_STATUS: prdata_d[IDX_W+2:0] = {pd, rat_on, div_busy, act_idx};
                        default: ;
                    endcase
                end
            end
        end
        // writes land only at the completing edge
        if (wr_ok) begin
            if (idx >= IDX_FREQ_BASE && idx < IDX_FREQ_END) begin
                freq_d[idx[IDX_W-1:0]] = pwdata;
            end else if (idx >= IDX_PHASE_BASE && idx < IDX_PHASE_END) begin
                phoff_d[idx[IDX_W-1:0]] = pwdata[PHASE_W-1:0];
            end else begin
                case (idx)
                    IDX_GAIN_A: gain_a_d = pwdata[TRIM_W-1:0];
                    IDX_GAIN_B: gain_b_d = pwdata[TRIM_W-1:0];
                    IDX_OFFS_A: offs_a_d = pwdata[TRIM_W-1:0];
                    IDX_OFFS_B: offs_b_d = pwdata[TRIM_W-1:0];
                    IDX_SRC_CFG: src_d = pwdata[SRC_BIT];
                    IDX_SEL: sel_d = pwdata[IDX_W-1:0];
                    IDX_RDIV: rdiv_d = pwdata[RDIV_W-1:0];
                    IDX_CTRL: ctrl_d = pwdata[CTRL_W-1:0];
                    default: ;
                endcase
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gain_a_q <= TRIM_RST;
            gain_b_q <= TRIM_RST;
            offs_a_q <= TRIM_RST;
            offs_b_q <= TRIM_RST;
            src_q <= 1'b0;
            sel_q <= '0;
            freq_q <= '{default: '0};
            phoff_q <= '{default: '0};
            rdiv_q <= RDIV_RST;
            ctrl_q <= CTRL_RST;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= '0;
        end else if (ce) begin
            gain_a_q <= gain_a_d;
            gain_b_q <= gain_b_d;
            offs_a_q <= offs_a_d;
            offs_b_q <= offs_b_d;
            src_q <= src_d;
            sel_q <= sel_d;
            freq_q <= freq_d;
            phoff_q <= phoff_d;
            rdiv_q <= rdiv_d;
            ctrl_q <= ctrl_d;
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
            prdata_q <= prdata_d;
        end
    end

    assign pd = ctrl_q[CTRL_PD_BIT];
    // a zero divisor has no modulus, so basic mode is used
    assign rat_on = ctrl_q[CTRL_RAT_BIT] & (rdiv_q != '0);

    // scale divider: floor(2^25 / divisor)
    ddcnm_div_state_t dst_q, dst_d;
    logic [4:0] dcnt_q, dcnt_d;
    logic [RDIV_W-1:0] rem_q, rem_d;
    logic [SCALE_W-1:0] quo_q, quo_d, scale_q, scale_d;
    logic [RDIV_W:0] trial;

    // restoring division, a bit per clock; a new write restarts it
    always_comb begin
        dst_d = dst_q;
        dcnt_d = dcnt_q;
        rem_d = rem_q;
        quo_d = quo_q;
        scale_d = scale_q;
        trial = {rem_q, dcnt_q == DIV_STEPS};
        unique case (dst_q)
            DDCNM_DIV_IDLE: begin
                if (rdiv_wr) begin
                    dst_d = DDCNM_DIV_RUN;
                    dcnt_d = DIV_STEPS;
                    rem_d = '0;
                    quo_d = '0;
                end
            end
            DDCNM_DIV_RUN: begin
                if (trial >= {1'b0, rdiv_q}) begin
                    rem_d = RDIV_W'(trial - {1'b0, rdiv_q});
                    quo_d = {quo_q[SCALE_W-2:0], 1'b1};
                end else begin
                    rem_d = trial[RDIV_W-1:0];
                    quo_d = {quo_q[SCALE_W-2:0], 1'b0};
                end
                dcnt_d = dcnt_q - 5'd1;
                if (dcnt_q == '0) begin
                    scale_d = quo_d;
                    dst_d = DDCNM_DIV_IDLE;
                end
                if (rdiv_wr) begin
                    dcnt_d = DIV_STEPS;
                    rem_d = '0;
                    quo_d = '0;
                    dst_d = DDCNM_DIV_RUN;
                end
            end
            default: dst_d = DDCNM_DIV_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dst_q <= DDCNM_DIV_IDLE;
            dcnt_q <= '0;
            rem_q <= '0;
            quo_q <= '0;
            scale_q <= SCALE_RST;
        end else if (ce) begin
            dst_q <= dst_d;
            dcnt_q <= dcnt_d;
            rem_q <= rem_d;
            quo_q <= quo_d;
            scale_q <= scale_d;
        end
    end

    assign div_busy = (dst_q == DDCNM_DIV_RUN);

    // oscillator, mixer outputs
    logic [IDX_W-1:0] pin_s1_q, pin_s2_q, act_q;
    logic [31:0] acc_q [N_PRESETS];
    logic [31:0] acc_d [N_PRESETS];
    logic [RACC_W-1:0] modulus;
    logic [RACC_W+SCALE_W-1:0] rat_prod;
    logic [31:0] acc_act, phase;
    logic signed [TRIG_W-1:0] cos_q, cos_d, sin_q, sin_d;
    logic [2*TRIM_W-1:0] gtrim_q, gtrim_d, otrim_q, otrim_d;
    logic drv_q;

    // source of the active index
    assign act_idx = src_q ? sel_q : pin_s2_q;
    assign modulus = {rdiv_q, {STEP_SHIFT{1'b0}}};

    // every preset steps each clock, selected or not; power-down holds all at zero
    always_comb begin
        for (int k = 0; k < N_PRESETS; k++) begin
            acc_d[k] = acc_q[k] + freq_q[k];
            if (rat_on) begin
                // step count wraps exactly at 128 x divisor
                if ((acc_q[k] + freq_q[k]) >= {{(32-RACC_W){1'b0}}, modulus}) begin
                    acc_d[k] = acc_q[k] + freq_q[k] - {{(32-RACC_W){1'b0}}, modulus};
                end
            end
            if (pd) begin
                acc_d[k] = '0;
            end
        end
    end

    // rational count rescaled to a full turn before the offset
    assign acc_act = acc_q[act_idx];
    assign rat_prod = acc_act[RACC_W-1:0] * scale_q;
    assign phase = (rat_on ? rat_prod[31:0] : acc_act) +
                   {phoff_q[act_idx], {(32-PHASE_W){1'b0}}};

    always_comb begin
        cos_d = sine_of(phase[31:32-LUT_W] + QUARTER);
        sin_d = sine_of(phase[31:32-LUT_W]);
        gtrim_d = {gain_b_q, gain_a_q};
        // background calibration owns the offset
        otrim_d = ctrl_q[CTRL_BGCAL_BIT] ? '0 : {offs_b_q, offs_a_q};
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_s1_q <= '0;
            pin_s2_q <= '0;
            act_q <= '0;
            acc_q <= '{default: '0};
            cos_q <= '0;
            sin_q <= '0;
            gtrim_q <= '0;
            otrim_q <= '0;
            drv_q <= 1'b0;
        end else if (ce) begin
            pin_s1_q <= preset_select_pins;
            pin_s2_q <= pin_s1_q;
            act_q <= act_idx;
            acc_q <= acc_d;
            cos_q <= cos_d;
            sin_q <= sin_d;
            gtrim_q <= gtrim_d;
            otrim_q <= otrim_d;
            drv_q <= ~pd;
        end
    end

    // mixer feeds the buffer, whose ready stalls the source
    ddcnm_stream_if #(.W(OUT_W)) up_if ();
    ddcnm_stream_if #(.W(OUT_W)) dn_if ();

    assign up_if.valid = adc_valid & ~pd;
    assign up_if.i_data = OUT_W'($signed(adc_sample) * cos_q);
    assign up_if.q_data = OUT_W'($signed(adc_sample) * sin_q);
    assign dn_if.ready = out_ready;

    // power-down empties the buffer: no stale word leaves
    ddcnm_pair_buf #(.W(OUT_W)) u_buf (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .flush(pd),
        .up(up_if.sink),
        .dn(dn_if.source)
    );

    assign pready = pready_q;
    assign prdata = prdata_q;
    assign pslverr = pslverr_q;
    assign adc_ready = up_if.ready;
    assign out_valid = dn_if.valid;
    assign out_i = dn_if.i_data;
    assign out_q = dn_if.q_data;
    assign serial_drive_en = drv_q;
    assign active_preset = act_q;
    assign full_scale_trim = gtrim_q;
    assign input_offset_trim = otrim_q;
endmodule // ddcnm_top

/* inc/ddcnm_pkg.sv */
package ddcnm_pkg;
    // preset structure
    localparam int unsigned N_PRESETS = 8;
    localparam int unsigned IDX_W = 3;
    // apb geometry: byte address is four times the index
    localparam int unsigned ADDR_W = 14;
    localparam int unsigned BYTE_SHIFT = 2;
    localparam int unsigned REG_IDX_W = 12;
    // register indices
    localparam logic [11:0] IDX_GAIN_A = 12'h022;
    localparam logic [11:0] IDX_GAIN_B = 12'h023;
    localparam logic [11:0] IDX_OFFS_A = 12'h025;
    localparam logic [11:0] IDX_OFFS_B = 12'h026;
    localparam logic [11:0] IDX_SRC_CFG = 12'h20C;
    localparam logic [11:0] IDX_SEL = 12'h20D;
    localparam logic [11:0] IDX_FREQ_BASE = 12'h100;
    localparam logic [11:0] IDX_FREQ_END = 12'h108;
    localparam logic [11:0] IDX_PHASE_BASE = 12'h108;
    localparam logic [11:0] IDX_PHASE_END = 12'h110;
    localparam logic [11:0] IDX_RDIV = 12'h110;
    localparam logic [11:0] IDX_CTRL = 12'h111;
    localparam logic [11:0] IDX_STATUS = 12'h112;
    // field positions
    localparam int unsigned SRC_BIT = 0;
    localparam int unsigned CTRL_PD_BIT = 0;
    localparam int unsigned CTRL_RAT_BIT = 1;
    localparam int unsigned CTRL_BGCAL_BIT = 2;
    localparam int unsigned CTRL_W = 3;
    localparam int unsigned TRIM_W = 8;
    localparam int unsigned PHASE_W = 16;
    // reset values
    localparam logic [7:0] TRIM_RST = 8'h80;
    localparam logic [2:0] CTRL_RST = 3'h0;
    localparam logic [15:0] RDIV_RST = 16'h0001;
    // rational mode arithmetic
    localparam int unsigned RDIV_W = 16;
    localparam int unsigned STEP_SHIFT = 7;
    localparam int unsigned FRAC_SHIFT = 25;
    localparam int unsigned RACC_W = RDIV_W + STEP_SHIFT;
    localparam int unsigned SCALE_W = FRAC_SHIFT + 1;
    localparam logic [25:0] SCALE_RST = 26'h200_0000;
    localparam logic [4:0] DIV_STEPS = 5'h19;
    // sine generator
    localparam int unsigned TRIG_W = 8;
    localparam int unsigned LUT_W = 4;
    localparam logic [3:0] QUARTER = 4'h4;

    typedef enum logic [1:0] {
        DDCNM_DIV_IDLE = 2'b01,
        DDCNM_DIV_RUN = 2'b10
    } ddcnm_div_state_t;
endpackage

/* inc/ddcnm_stream_if.sv */
`timescale 1ns/1ps
// complex sample stream, valid/ready
interface ddcnm_stream_if #(parameter int unsigned W = 20);
    logic valid;
    logic ready;
    logic [W-1:0] i_data;
    logic [W-1:0] q_data;
    modport source(output valid, output i_data, output q_data, input ready);
    modport sink(input valid, input i_data, input q_data, output ready);
endinterface

/* verification/ddcnm_chk.sv */
`timescale 1ns/1ps
// port-level checks on the mixer top
module ddcnm_chk #(parameter int unsigned SAMPLE_W = 12) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic adc_valid,
    input wire logic adc_ready,
    input wire logic out_valid,
    input wire logic out_ready,
    input wire logic [SAMPLE_W+ddcnm_pkg::TRIG_W-1:0] out_i,
    input wire logic [SAMPLE_W+ddcnm_pkg::TRIG_W-1:0] out_q,
    input wire logic serial_drive_en,
    input wire logic [2*ddcnm_pkg::TRIM_W-1:0] full_scale_trim,
    input wire logic [2*ddcnm_pkg::TRIM_W-1:0] input_offset_trim
);
    import ddcnm_pkg::*;
    // completed write; trims follow two cycles later
    wire wr_done = psel && penable && pwrite && pready;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_ready_after_setup;
        psel && !penable |=> pready;
    endproperty
    property p_ready_in_access;
        pready |-> psel && penable && $past(psel && !penable);
    endproperty
    property p_err_with_ready;
        pslverr |-> pready ##1 !pready;
    endproperty
    property p_out_hold;
        out_valid && !out_ready |=> (out_valid && $stable(out_i) && $stable(out_q))
            || !serial_drive_en;
    endproperty
    property p_out_cause;
        $rose(out_valid) |-> $past(adc_valid && adc_ready);
    endproperty
    property p_pd_quiet;
        !serial_drive_en |-> !out_valid;
    endproperty
    property p_fs_trim;
        $changed(full_scale_trim) |-> $past(wr_done, 2) || !$past(presetn, 2);
    endproperty
    property p_offs_trim;
        $changed(input_offset_trim) |-> $past(wr_done, 2) || !$past(presetn, 2);
    endproperty
    property p_drive_cause;
        $changed(serial_drive_en) |-> $past(wr_done, 2) || !$past(presetn, 2);
    endproperty
    a_ready_after_setup: assert property (p_ready_after_setup) else $error("no ready after setup");
    a_ready_in_access: assert property (p_ready_in_access) else $error("ready outside access");
    a_err_with_ready: assert property (p_err_with_ready) else $error("error without ready");
    a_out_hold: assert property (p_out_hold) else $error("output word not held");
    a_out_cause: assert property (p_out_cause) else $error("output without input");
    a_pd_quiet: assert property (p_pd_quiet) else $error("output while powered down");
    a_fs_trim: assert property (p_fs_trim) else $error("gain trim moved alone");
    a_offs_trim: assert property (p_offs_trim) else $error("offset trim moved alone");
    a_drive_cause: assert property (p_drive_cause) else $error("drive enable moved alone");
    c_stall: cover property (out_valid && !out_ready);
    c_err: cover property (pslverr);
    c_pd_exit: cover property (!serial_drive_en ##1 serial_drive_en);
    c_full: cover property ($fell(adc_ready));
endmodule // ddcnm_chk

bind ddcnm_top ddcnm_chk #(.SAMPLE_W(SAMPLE_W)) u_chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pready(pready), .pslverr(pslverr),
    .adc_valid(adc_valid), .adc_ready(adc_ready), .out_valid(out_valid),
    .out_ready(out_ready), .out_i(out_i), .out_q(out_q), .serial_drive_en(serial_drive_en),
    .full_scale_trim(full_scale_trim), .input_offset_trim(input_offset_trim));

/* verification/ddcnm_far_model.sv */
`timescale 1ns/1ps
// downstream controller: preset pins, output sink
module ddcnm_far_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic stall,
    input wire logic slow,
    input wire logic [2:0] want_idx,
    input wire logic out_valid,
    input wire logic [19:0] out_i,
    input wire logic [19:0] out_q,
    output logic out_ready,
    output logic [2:0] preset_select_pins
);
    logic [19:0] got_i[$];
    logic [19:0] got_q[$];
    logic tick_q;
    // pins move after an edge; slow takes every other cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            preset_select_pins <= 3'h0;
            out_ready <= 1'b0;
            tick_q <= 1'b0;
        end else begin
            preset_select_pins <= want_idx;
            tick_q <= !tick_q;
            if (out_valid && out_ready) begin
                got_i.push_back(out_i);
                got_q.push_back(out_q);
            end
            out_ready <= !stall && (!slow || tick_q);
        end
    end
endmodule // ddcnm_far_model

/* verification/tb.sv */
`timescale 1ns/1ps
module tb;
    import ddcnm_pkg::*;
    logic pclk, presetn = 1'b0, ce = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [13:0] paddr = 14'h0000;
    logic [31:0] pwdata = 32'h0000_0000, prdata;
    logic [11:0] adc_sample = 12'h010;
    logic adc_valid = 1'b0, stall = 1'b0, slow = 1'b0;
    logic [2:0] want_idx = 3'h0, pins, active_preset;
    logic pready, pslverr, adc_ready, out_valid, out_ready, serial_drive_en;
    logic [19:0] out_i, out_q, gi, gq;
    logic [15:0] full_scale_trim, input_offset_trim;
    int n_mismatch = 0, compares = 0, cyc = 0, nb = 0;
    int sn[16] = '{0, 49, 90, 117, 127, 117, 90, 49, 0, -49, -90, -117, -127, -117, -90, -49};

    ddcnm_top dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .preset_select_pins(pins), .adc_sample(adc_sample),
        .adc_valid(adc_valid), .adc_ready(adc_ready), .out_valid(out_valid),
        .out_ready(out_ready), .out_i(out_i), .out_q(out_q),
        .serial_drive_en(serial_drive_en), .active_preset(active_preset),
        .full_scale_trim(full_scale_trim), .input_offset_trim(input_offset_trim));
    ddcnm_far_model far (.pclk(pclk), .presetn(presetn), .stall(stall), .slow(slow),
        .want_idx(want_idx), .out_valid(out_valid), .out_i(out_i), .out_q(out_q),
        .out_ready(out_ready), .preset_select_pins(pins));

    initial begin
        pclk = 1'b0;
        forever #4 pclk = !pclk;
    end

    // hang guard, far above the run's length
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            close_out;
        end
    end

    task automatic close_out;
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, g);
        compares++;
        if (g !== e) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    // one apb transfer; clean reads compare data
    task automatic acc(input logic w, input logic [11:0] idx, input logic [31:0] d,
                       input logic ee, input string nm);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        chk({nm, "_err"}, 32'(ee), 32'(pslverr));
        if (!w && !ee) chk(nm, d, prdata);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    // hold valid until n samples taken
    task automatic send(input int n);
        int k;
        k = 0;
        adc_valid <= 1'b1;
        while (k < n) begin
            @(posedge pclk);
            if (adc_ready === 1'b1) k++;
        end
        adc_valid <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic get(output logic [19:0] i, q);
        while (far.got_i.size() == 0) @(posedge pclk);
        i = far.got_i.pop_front();
        q = far.got_q.pop_front();
    endtask

    // a half-turn step flips the i sign each sample
    task automatic alt(input int n);
        logic [19:0] a, b, q;
        get(a, q);
        chk("alt_mag", 32'h0000_07F0, 32'(a[19] ? -signed'(a) : signed'(a)));
        for (int k = 1; k < n; k++) begin
            get(b, q);
            chk("alt_i", 32'(-signed'(a)), 32'(signed'(b)));
            chk("alt_q", 32'h0000_0000, 32'(q));
            a = b;
        end
    endtask

    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        acc(0, IDX_GAIN_A, 32'h0000_0080, 0, "fs_a");
        acc(0, IDX_OFFS_B, 32'h0000_0080, 0, "off_b");
        acc(0, IDX_SRC_CFG, 32'h0000_0000, 0, "src");
        acc(0, IDX_SEL, 32'h0000_0000, 0, "sel");
        acc(0, IDX_RDIV, 32'h0000_0001, 0, "rdiv");
        acc(0, 12'h3FF, 32'h0000_0000, 1, "hole");
        acc(1, IDX_GAIN_A, 32'h0000_0012, 0, "w");
        acc(1, IDX_GAIN_B, 32'h0000_0034, 0, "w");
        acc(1, IDX_OFFS_A, 32'h0000_0056, 0, "w");
        acc(1, IDX_OFFS_B, 32'h0000_0078, 0, "w");
        repeat (2) @(posedge pclk);
        chk("fs_trim", 32'h0000_3412, 32'(full_scale_trim));
        chk("off_trim", 32'h0000_7856, 32'(input_offset_trim));
        acc(1, IDX_CTRL, 32'h0000_0004, 0, "w");
        repeat (2) @(posedge pclk);
        chk("off_cal", 32'h0000_0000, 32'(input_offset_trim));
        acc(1, IDX_CTRL, 32'h0000_0000, 0, "w");
        for (int k = 0; k < 8; k++) begin
            acc(1, IDX_PHASE_BASE + 12'(k), 32'(k) << 12, 0, "w");
        end
        // pins, then register with pins disagreeing
        for (int k = 0; k < 16; k++) begin
            want_idx <= 3'(k);
            if (k == 8) acc(1, IDX_SRC_CFG, 32'h0000_0001, 0, "w");
            if (k >= 8) acc(1, IDX_SEL, 32'(15 - k), 0, "w");
            repeat (5) @(posedge pclk);
            nb = k < 8 ? k : 15 - k;
            chk("active", 32'(nb), 32'(active_preset));
            send(1);
            get(gi, gq);
            chk("mix_i", 32'(16 * sn[(nb + 4) % 16]), 32'(signed'(gi)));
            chk("mix_q", 32'(16 * sn[nb]), 32'(signed'(gq)));
        end
        // stalled sink holds two; slow drain loses none
        stall <= 1'b1;
        adc_valid <= 1'b1;
        nb = 0;
        repeat (12) begin
            @(posedge pclk);
            if (adc_ready === 1'b1) nb++;
        end
        chk("held", 32'h0000_0002, 32'(nb));
        stall <= 1'b0;
        slow <= 1'b1;
        send(4);
        for (int k = 0; k < 6; k++) begin
            get(gi, gq);
            chk("drain_i", 32'h0000_07F0, 32'(signed'(gi)));
        end
        slow <= 1'b0;
        acc(1, IDX_FREQ_BASE, 32'h8000_0000, 0, "w");
        send(6);
        alt(6);
        acc(1, IDX_FREQ_BASE, 32'h0000_0080, 0, "w");
        acc(1, IDX_RDIV, 32'h0000_0002, 0, "w");
        acc(1, IDX_CTRL, 32'h0000_0003, 0, "w");
        repeat (2) @(posedge pclk);
        chk("drive_en", 32'h0000_0000, 32'(serial_drive_en));
        acc(1, IDX_CTRL, 32'h0000_0002, 0, "w");
        repeat (40) @(posedge pclk);
        chk("drive_en", 32'h0000_0001, 32'(serial_drive_en));
        send(6);
        alt(6);
        close_out;
    end
endmodule // tb
